// ===== src/cgs_top.sv
// Clock generator and selector: PLL dividers, system, CPU, peripheral,
// flow/NAND, card and serial clocks as one-cycle tick pulses.
// Assumes PLL-derived ticks and the raw lock arrive synchronous to core_clk_i.
`timescale 1ns/100ps
module cgs_top
  import cgs_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_FILTER_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic osc_tick_i,
  input wire logic [8:0] pll_tick_i,
  input wire logic pll_lock_raw_i,
  input wire logic idle_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic pll_enable_o,
  output logic pll_ref_tick_o,
  output logic pll_cmp_tick_o,
  output logic sys_tick_o,
  output logic cpu_tick_o,
  output logic per_tick_o,
  output logic flow_nand_tick_o,
  output logic card_tick_o,
  output logic serial_tick_o
);
  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [3:0] sys_idx(input logic [1:0] c);
    unique case (c)
      2'h0: sys_idx = SRC_OSC;
      2'h1: sys_idx = SRC_24;
      2'h2: sys_idx = SRC_30;
      2'h3: sys_idx = SRC_40;
    endcase
  endfunction
  function automatic logic [3:0] fn_idx(input logic [2:0] c);
    unique case (c)
      3'h0: fn_idx = SRC_OSC;
      3'h1: fn_idx = SRC_60;
      3'h2: fn_idx = SRC_48;
      3'h3: fn_idx = SRC_40;
      3'h4: fn_idx = SRC_30;
      3'h5: fn_idx = SRC_24;
      3'h6: fn_idx = SRC_20;
      3'h7: fn_idx = SRC_16;
    endcase
  endfunction
  function automatic logic [3:0] card_idx(input logic [2:0] c);
    unique case (c)
      3'h0: card_idx = SRC_OSC;
      3'h1: card_idx = SRC_60;
      3'h2: card_idx = SRC_48;
      3'h3: card_idx = SRC_30;
      3'h4: card_idx = SRC_24;
      3'h5: card_idx = SRC_20;
      3'h6: card_idx = SRC_16;
      3'h7: card_idx = SRC_OSC2;
    endcase
  endfunction
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] pll_config_q, pll_config_d;
  logic [7:0] clock_select_q, clock_select_d;
  logic [7:0] clock_control_q, clock_control_d;
  logic [7:0] clock_enable_q, clock_enable_d;
  logic [7:0] card_clock_q, card_clock_d;
  logic [DATA_W-1:0] rd_data_d;
  logic [15:0] lock_cnt_q, lock_cnt_d;
  logic locked_q, locked_d;
  always_comb
  begin
    pll_config_d = pll_config_q;
    clock_select_d = clock_select_q;
    clock_control_d = clock_control_q;
    clock_enable_d = clock_enable_q;
    card_clock_d = card_clock_q;
    rd_data_d = '0;
    if (wr_en_i)
    begin
      unique case (addr_i)
        PLL_CONFIG_OFS: pll_config_d = wr_data_i;
        CLOCK_SELECT_OFS: clock_select_d = wr_data_i;
        CLOCK_CONTROL_OFS: clock_control_d = {7'h00, wr_data_i[0]};
        CLOCK_ENABLE_OFS: clock_enable_d = wr_data_i & 8'hcb;
        CARD_CLOCK_OFS: card_clock_d = wr_data_i;
        default: ;
      endcase
    end
    if (rd_en_i)
    begin
      unique case (addr_i)
        PLL_CONFIG_OFS: rd_data_d = pll_config_q;
        CLOCK_SELECT_OFS: rd_data_d = clock_select_q;
        CLOCK_CONTROL_OFS: rd_data_d = clock_control_q;
        CLOCK_ENABLE_OFS:
          rd_data_d = clock_enable_q | ({7'h00, locked_q} << LOCK_BIT);
        CARD_CLOCK_OFS: rd_data_d = card_clock_q;
        default: rd_data_d = '0;
      endcase
    end
    // Lock must hold unbroken for the whole filter time
    lock_cnt_d = '0;
    if (clock_enable_q[PLL_EN_BIT] && pll_lock_raw_i)
      lock_cnt_d = (lock_cnt_q >= 16'(LOCK_CYC)) ? lock_cnt_q
                                                 : 16'(lock_cnt_q + 1'b1);
    locked_d = clock_enable_q[PLL_EN_BIT] && lock_cnt_d >= 16'(LOCK_CYC);
  end
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pll_config_q <= REG_RESET;
      clock_select_q <= REG_RESET;
      clock_control_q <= REG_RESET;
      clock_enable_q <= REG_RESET;
      card_clock_q <= REG_RESET;
      rd_data_o <= '0;
      lock_cnt_q <= '0;
      locked_q <= 1'b0;
      pll_enable_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pll_config_q <= pll_config_d;
      clock_select_q <= clock_select_d;
      clock_control_q <= clock_control_d;
      clock_enable_q <= clock_enable_d;
      card_clock_q <= card_clock_d;
      rd_data_o <= rd_data_d;
      lock_cnt_q <= lock_cnt_d;
      locked_q <= locked_d;
      pll_enable_o <= clock_enable_d[PLL_EN_BIT];
    end
  end

  // ************************************************************
  // Source ticks
  // ************************************************************
  logic gen_run;
  logic osc2_tick;
  logic [NSRC-1:0] src_v;
  logic fb_tick;
  // Without lock the PLL ticks may be off-frequency, so hold them back
  assign gen_run = clock_enable_q[GEN_EN_BIT] && locked_q;
  assign src_v = {osc2_tick, pll_tick_i & {9{gen_run}}, osc_tick_i};
  cgs_tick_div #(.W(2)) u_osc2 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(osc_tick_i),
    .ratio_i(2'h2),
    .tick_o(osc2_tick)
  );
  cgs_tick_div #(.W(5)) u_ref (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(osc_tick_i),
    .ratio_i(5'(pll_config_q[REF_DIV_LSB +: 4]) + 5'h01),
    .tick_o(pll_ref_tick_o)
  );
  cgs_tick_div #(.W(5)) u_fb (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(src_v[SRC_12]),
    .ratio_i(5'(pll_config_q[FB_DIV_LSB +: 4]) + 5'h01),
    .tick_o(fb_tick)
  );

  // ************************************************************
  // Selectors
  // ************************************************************
  logic [3:0] sys_cur_q, sys_cur_d, fn_cur_q, fn_cur_d;
  logic [3:0] card_cur_q, card_cur_d;
  logic ser_cur_q, ser_cur_d;
  logic cmp_d, sys_d, fn_d, ser_d;
  logic [1:0] fb_src;
  assign fb_src = clock_select_q[FB_SRC_LSB +: 2];
  // Switch only on the old source's tick, or while PLL ticks are held back (system clock: only when off the oscillator)
  always_comb
  begin
    sys_cur_d = sys_cur_q;
    fn_cur_d = fn_cur_q;
    card_cur_d = card_cur_q;
    ser_cur_d = ser_cur_q;
    if (src_v[sys_cur_q] || (!gen_run && sys_cur_q != SRC_OSC))
      sys_cur_d = sys_idx(clock_select_q[SYS_SRC_LSB +: 2]);
    if (src_v[fn_cur_q] || !gen_run)
      fn_cur_d = fn_idx(clock_select_q[FN_SRC_LSB +: 3]);
    if (src_v[card_cur_q] || !gen_run)
      card_cur_d = card_idx(card_clock_q[CARD_SRC_LSB +: 3]);
    if ((ser_cur_q ? src_v[SRC_120] : osc_tick_i) || !gen_run)
      ser_cur_d = clock_select_q[SER_SRC_BIT];
    unique case (fb_src)
      2'h0: cmp_d = src_v[SRC_12];
      2'h1: cmp_d = src_v[SRC_16];
      2'h2: cmp_d = src_v[SRC_20];
      2'h3: cmp_d = fb_tick;
    endcase
    sys_d = src_v[sys_cur_q];
    // One tick feeds both controllers
    fn_d = src_v[fn_cur_q] && clock_enable_q[FN_EN_BIT];
    ser_d = (ser_cur_q ? src_v[SRC_120] : osc_tick_i)
            && clock_enable_q[SER_EN_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      sys_cur_q <= SRC_OSC;
      fn_cur_q <= SRC_OSC;
      card_cur_q <= SRC_OSC;
      ser_cur_q <= 1'b0;
      pll_cmp_tick_o <= 1'b0;
      sys_tick_o <= 1'b0;
      flow_nand_tick_o <= 1'b0;
      serial_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      sys_cur_q <= sys_cur_d;
      fn_cur_q <= fn_cur_d;
      card_cur_q <= card_cur_d;
      ser_cur_q <= ser_cur_d;
      pll_cmp_tick_o <= cmp_d;
      sys_tick_o <= sys_d;
      flow_nand_tick_o <= fn_d;
      serial_tick_o <= ser_d;
    end
  end

  // ************************************************************
  // CPU, peripheral and card clocks
  // ************************************************************
  logic per_tick;
  logic card_in;
  logic per_d, cpu_d;
  // Peripheral timers run at half the system tick rate, or at the full rate in double speed
  cgs_tick_div #(.W(2)) u_x2 (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(sys_tick_o),
    .ratio_i(clock_control_q[DOUBLE_SPEED_BIT] ? 2'h1 : 2'h2),
    .tick_o(per_tick)
  );
  // Card enable gates the source so a late enable starts cleanly
  assign card_in = src_v[card_cur_q] && clock_enable_q[CARD_EN_BIT];
  cgs_tick_div #(.W(5)) u_card (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tick_i(card_in),
    .ratio_i(card_clock_q[CARD_DIV_LSB +: 5]),
    .tick_o(card_tick_o)
  );

  always_comb
  begin
    per_d = per_tick;
    cpu_d = per_tick && !idle_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      per_tick_o <= 1'b0;
      cpu_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      per_tick_o <= per_d;
      cpu_tick_o <= cpu_d;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_lock_needs_en: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && !clock_enable_q[PLL_EN_BIT] |=> !locked_q)
    else $error("lock flag set with PLL disabled");
  a_flow_gate_off: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && !clock_enable_q[FN_EN_BIT] |=> !flow_nand_tick_o)
    else $error("flow/NAND tick while disabled");
  a_serial_gate_off: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && !clock_enable_q[SER_EN_BIT] |=> !serial_tick_o)
    else $error("serial tick while disabled");
  a_card_div_zero: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && card_clock_q[CARD_DIV_LSB +: 5] == 5'h00
    |=> !card_tick_o)
    else $error("card tick with zero divider");
  a_cpu_idle_stop: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && idle_i && per_tick |=> !cpu_tick_o && per_tick_o)
    else $error("CPU tick in idle or peripheral tick lost");
  a_gen_off_serial: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && !gen_run && ser_cur_q |=> !serial_tick_o)
    else $error("PLL-derived serial tick with generator off");
  a_std_half_rate: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && !clock_control_q[DOUBLE_SPEED_BIT] && sys_tick_o
    ##1 ce_i && sys_tick_o && $stable(clock_control_q)
    |-> !(per_tick && $past(per_tick)))
    else $error("standard mode passed two system ticks in a row");
  a_sys_osc_path: assert property (@(posedge core_clk_i) disable iff
    (!rst_n_i) ce_i && sys_cur_q == SRC_OSC
    |=> sys_tick_o == $past(osc_tick_i))
    else $error("system tick does not follow oscillator");
endmodule // cgs_top

// ===== inc/cgs_pkg.sv
// Constants for the clock generator and selector block.
// Assumes a single 100 MHz core clock; all clocks are carried as tick pulses.
package cgs_pkg;
  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [2:0] PLL_CONFIG_OFS = 3'h0;
  localparam logic [2:0] CLOCK_SELECT_OFS = 3'h1;
  localparam logic [2:0] CLOCK_CONTROL_OFS = 3'h2;
  localparam logic [2:0] CLOCK_ENABLE_OFS = 3'h3;
  localparam logic [2:0] CARD_CLOCK_OFS = 3'h4;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int REF_DIV_LSB = 0;
  localparam int FB_DIV_LSB = 4;
  localparam int SYS_SRC_LSB = 0;
  localparam int FN_SRC_LSB = 2;
  localparam int SER_SRC_BIT = 5;
  localparam int FB_SRC_LSB = 6;
  localparam int DOUBLE_SPEED_BIT = 0;
  localparam int GEN_EN_BIT = 7;
  localparam int PLL_EN_BIT = 6;
  localparam int LOCK_BIT = 4;
  localparam int CARD_EN_BIT = 3;
  localparam int SER_EN_BIT = 1;
  localparam int FN_EN_BIT = 0;
  localparam int CARD_SRC_LSB = 0;
  localparam int CARD_DIV_LSB = 3;
  // ************************************************************
  // Tick sources
  // ************************************************************
  localparam int NSRC = 11;
  localparam logic [3:0] SRC_OSC = 4'h0;
  localparam logic [3:0] SRC_120 = 4'h1;
  localparam logic [3:0] SRC_60 = 4'h2;
  localparam logic [3:0] SRC_48 = 4'h3;
  localparam logic [3:0] SRC_40 = 4'h4;
  localparam logic [3:0] SRC_30 = 4'h5;
  localparam logic [3:0] SRC_24 = 4'h6;
  localparam logic [3:0] SRC_20 = 4'h7;
  localparam logic [3:0] SRC_16 = 4'h8;
  localparam logic [3:0] SRC_12 = 4'h9;
  localparam logic [3:0] SRC_OSC2 = 4'ha;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCK_FILTER_NS = 10000;
  localparam int LOCK_FILTER_CYC =
    (LOCK_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== src/cgs_tick_div.sv
// Tick divider: passes one of every ratio input ticks, ratio zero stops it.
// Assumes ticks and ratio are synchronous to core_clk_i.
`timescale 1ns/100ps
module cgs_tick_div #(
  parameter int W = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_d;

  // Compare with >= so a smaller ratio never strands the count
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (tick_i && ratio_i != '0)
    begin
      if (cnt_q >= W'(ratio_i - 1'b1))
      begin
        cnt_d = '0;
        tick_d = 1'b1;
      end
      else
      begin
        cnt_d = W'(cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule // cgs_tick_div

// ===== dv/cgs_top_test.sv
// Self-checking bench for the clock generator and selector top.
// Assumes cgs_pkg and cgs_top compiled first; bench drives every port.
`timescale 1ns/100ps
module cgs_top_test
  import cgs_pkg::*;
;
  // ************************************************************
  // Stimulus sources
  // ************************************************************
  localparam int OSC_P = 6;
  // Tick periods in core cycles: PP in lane order of pll_tick_i, FNP and CDP in select code order
  localparam int PP [9] = '{2, 3, 4, 5, 7, 8, 9, 10, 11};
  localparam int FNP [8] = '{6, 3, 4, 5, 7, 8, 9, 10};
  localparam int CDP [8] = '{6, 3, 4, 7, 8, 9, 10, 12};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic osc_tick_i = 1'b0;
  logic [8:0] pll_tick_i = 9'h000;
  logic pll_lock_raw_i = 1'b0;
  logic idle_i = 1'b0;
  logic [7:0] rd_data_o;
  logic pll_enable_o;
  wire [7:0] tk;
  int osc_p = OSC_P;
  int osc_cnt = 0;
  int pll_cnt [9] = '{9{0}};
  int checks = 0;
  int miscompares = 0;
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    osc_cnt <= (osc_cnt >= osc_p - 1) ? 0 : osc_cnt + 1;
    osc_tick_i <= (osc_cnt >= osc_p - 1);
    for (int k = 0; k < 9; k++)
    begin
      pll_cnt[k] <= (pll_cnt[k] == PP[k] - 1) ? 0 : pll_cnt[k] + 1;
      pll_tick_i[k] <= (pll_cnt[k] == PP[k] - 1);
    end
  end
  cgs_top #(.LOCK_CYC(4)) u_dut (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .osc_tick_i(osc_tick_i), .pll_tick_i(pll_tick_i),
    .pll_lock_raw_i(pll_lock_raw_i), .idle_i(idle_i),
    .rd_data_o(rd_data_o), .pll_enable_o(pll_enable_o),
    .pll_ref_tick_o(tk[0]), .pll_cmp_tick_o(tk[1]), .sys_tick_o(tk[2]),
    .cpu_tick_o(tk[3]), .per_tick_o(tk[4]), .flow_nand_tick_o(tk[5]),
    .card_tick_o(tk[6]), .serial_tick_o(tk[7]));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge core_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge core_clk_i);
    rd_en_i <= 1'b0;
    #1;
    check("rd_data_o", {24'h0, rd_data_o}, {24'h0, exp});
  endtask
  // Last of four gaps counts, earlier ones let a switch settle
  task automatic gap(input int idx, input int exp);
    int n;
    int g;
    n = 0;
    g = 0;
    for (int t = 0; t < 4; t++)
    begin
      g = 0;
      do
      begin
        @(posedge core_clk_i);
        #1;
        g++;
        n++;
      end while (tk[idx] !== 1'b1 && n < 800);
    end
    if (n >= 800)
    begin
      miscompares++;
      $display("CHECK FAILED tick %0d expected %0d seen none", idx, exp);
      close_out();
    end
    check($sformatf("gap of tick %0d", idx), g, exp);
  endtask
  task automatic silent(input int idx);
    int s;
    s = 0;
    repeat (5) @(posedge core_clk_i);
    repeat (100)
    begin
      @(posedge core_clk_i);
      #1;
      if (tk[idx] === 1'b1)
        s++;
    end
    check($sformatf("ticks on %0d", idx), s, 0);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_pll();
    gap(4, 2 * OSC_P);
    check("pll_enable_o", {31'h0, pll_enable_o}, 0);
    wr(3'h3, 8'hc0);
    #1;
    check("pll_enable_o", {31'h0, pll_enable_o}, 1);
    repeat (10) @(posedge core_clk_i);
    rd(3'h3, 8'hc0);
    @(posedge core_clk_i);
    pll_lock_raw_i <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    rd(3'h3, 8'hd0);
    wr(3'h0, 8'hbc);
    gap(0, OSC_P * 13);
    wr(3'h1, 8'h00);
    gap(1, PP[8]);
    wr(3'h1, 8'h40);
    gap(1, PP[7]);
    wr(3'h1, 8'h80);
    gap(1, PP[6]);
    wr(3'h1, 8'hc0);
    gap(1, PP[8] * 12);
  endtask
  task automatic t_sys();
    wr(3'h2, 8'h01);
    for (int s = 1; s < 4; s++)
    begin
      wr(3'h1, s[7:0]);
      gap(2, PP[6 - s]);
      gap(4, PP[6 - s]);
    end
    wr(3'h1, 8'h00);
    gap(2, OSC_P);
    gap(4, OSC_P);
    wr(3'h2, 8'h00);
    gap(3, 2 * OSC_P);
    @(posedge core_clk_i);
    idle_i <= 1'b1;
    silent(3);
    gap(4, 2 * OSC_P);
    @(posedge core_clk_i);
    idle_i <= 1'b0;
    // Oscillator tick every cycle makes back-to-back system ticks
    osc_p <= 1;
    gap(2, 1);
    gap(4, 2);
    osc_p <= OSC_P;
  endtask
  task automatic t_flow();
    wr(3'h3, 8'hc1);
    for (int s = 0; s < 8; s++)
    begin
      wr(3'h1, 8'(s << 2));
      gap(5, FNP[s]);
    end
    wr(3'h3, 8'hc0);
    silent(5);
    wr(3'h1, 8'h04);
    wr(3'h3, 8'h41);
    silent(5);
    wr(3'h1, 8'h00);
    gap(5, OSC_P);
  endtask
  task automatic t_card();
    for (int s = 0; s < 8; s++)
    begin
      wr(3'h3, 8'hc0);
      wr(3'h4, {5'h01, 3'(s)});
      wr(3'h3, 8'hc8);
      gap(6, CDP[s]);
    end
    wr(3'h4, {5'h03, 3'h0});
    gap(6, 3 * OSC_P);
    wr(3'h4, {5'h1f, 3'h0});
    gap(6, 31 * OSC_P);
    wr(3'h4, 8'h00);
    silent(6);
  endtask
  task automatic t_serial();
    wr(3'h3, 8'hc2);
    wr(3'h1, 8'h00);
    gap(7, OSC_P);
    wr(3'h1, 8'h20);
    gap(7, PP[0]);
    wr(3'h3, 8'h42);
    silent(7);
    wr(3'h3, 8'hc0);
    silent(7);
  endtask
  task automatic t_reg();
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h01);
    wr(3'h3, 8'hff);
    rd(3'h3, 8'hdb);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00);
    wr(3'h4, 8'ha5);
    @(posedge core_clk_i);
    ce_i <= 1'b0;
    wr(3'h4, 8'h11);
    ce_i <= 1'b1;
    rd(3'h4, 8'ha5);
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 5; a++)
      rd(3'(a), 8'h00);
    t_pll();
    t_sys();
    t_flow();
    t_card();
    t_serial();
    t_reg();
    close_out();
  end
endmodule // cgs_top_test
